// >>> bsi_pkg.sv
// constants, state codes and register map of the scan instruction path
// assumes a 50 MHz system clock and a slow, externally driven scan clock
package bsi_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IR_LEN = 3;
    localparam int BSR_LEN_DEF = 32;
    localparam int ID_LEN = 32;
    localparam int PN_W = 16;
    localparam int SYNC_STAGES = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PART_NUM = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_ID_LATCH = 12'h00C;
    localparam int CTRL_SOFT_RST_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_INSTR_LSB = 4;
    localparam logic CTRL_RESET = 1'b0;

    // instruction codes
    localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h2;
    localparam logic [IR_LEN-1:0] INS_CLAMP = 3'h3;
    localparam logic [IR_LEN-1:0] INS_HIGHZ = 3'h4;
    localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;

    typedef enum logic [3:0] {
        ST_TLR = 4'b0000, ST_RTI = 4'b0001, ST_SDR = 4'b0010, ST_CDR = 4'b0011,
        ST_SHDR = 4'b0100, ST_E1DR = 4'b0101, ST_PDR = 4'b0110, ST_E2DR = 4'b0111,
        ST_UDR = 4'b1000, ST_SIR = 4'b1001, ST_CIR = 4'b1010, ST_SHIR = 4'b1011,
        ST_E1IR = 4'b1100, ST_PIR = 4'b1101, ST_E2IR = 4'b1110, ST_UIR = 4'b1111
    } bsi_tap_state_t;
endpackage : bsi_pkg

// >>> bsi_tap_if.sv
// carries scan clock strobes, mode select and controller state between modules
// assumes all members are on the system clock
`timescale 1ns/1ps
`default_nettype none
interface bsi_tap_if;
    import bsi_pkg::*;
    logic tck_rise;
    logic tms;
    logic soft_rst;
    bsi_tap_state_t state;
    modport fsm (input tck_rise, input tms, input soft_rst, output state);
    modport core (output tck_rise, output tms, output soft_rst, input state);
endinterface : bsi_tap_if
`default_nettype wire

// >>> bsi_tap_fsm.sv
// sixteen-state test access controller
// assumes tck_rise and tms are already synchronised; reset is the synchronised system and scan reset
`timescale 1ns/1ps
`default_nettype none
module bsi_tap_fsm (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    bsi_tap_if.fsm tap
);
    import bsi_pkg::*;
    bsi_tap_state_t state_reg;
    bsi_tap_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_TLR: state_next = tap.tms ? ST_TLR : ST_RTI;
            ST_RTI: state_next = tap.tms ? ST_SDR : ST_RTI;
            ST_SDR: state_next = tap.tms ? ST_SIR : ST_CDR;
            ST_CDR: state_next = tap.tms ? ST_E1DR : ST_SHDR;
            ST_SHDR: state_next = tap.tms ? ST_E1DR : ST_SHDR;
            ST_E1DR: state_next = tap.tms ? ST_UDR : ST_PDR;
            ST_PDR: state_next = tap.tms ? ST_E2DR : ST_PDR;
            ST_E2DR: state_next = tap.tms ? ST_UDR : ST_SHDR;
            ST_UDR: state_next = tap.tms ? ST_SDR : ST_RTI;
            ST_SIR: state_next = tap.tms ? ST_TLR : ST_CIR;
            ST_CIR: state_next = tap.tms ? ST_E1IR : ST_SHIR;
            ST_SHIR: state_next = tap.tms ? ST_E1IR : ST_SHIR;
            ST_E1IR: state_next = tap.tms ? ST_UIR : ST_PIR;
            ST_PIR: state_next = tap.tms ? ST_E2IR : ST_PIR;
            ST_E2IR: state_next = tap.tms ? ST_UIR : ST_SHIR;
            ST_UIR: state_next = tap.tms ? ST_SDR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_TLR;
        end else if (tap.soft_rst) begin
            state_reg <= ST_TLR;
        end else if (tap.tck_rise) begin
            state_reg <= state_next;
        end
    end

    assign tap.state = state_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b || tap.soft_rst);

    property p_cap_ir;
        tap.tck_rise && state_reg == ST_CIR |=> state_reg == ($past(tap.tms) ? ST_E1IR : ST_SHIR);
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("capture-ir exit wrong");
    property p_shift_ir;
        tap.tck_rise && state_reg == ST_SHIR |=> state_reg == ($past(tap.tms) ? ST_E1IR : ST_SHIR);
    endproperty
    a_shift_ir: assert property (p_shift_ir) else $error("shift-ir exit wrong");
    property p_exit1_ir;
        tap.tck_rise && state_reg == ST_E1IR |=> state_reg == ($past(tap.tms) ? ST_UIR : ST_PIR);
    endproperty
    a_exit1_ir: assert property (p_exit1_ir) else $error("exit1-ir exit wrong");
    property p_pause_ir;
        tap.tck_rise && state_reg == ST_PIR |=> state_reg == ($past(tap.tms) ? ST_E2IR : ST_PIR);
    endproperty
    a_pause_ir: assert property (p_pause_ir) else $error("pause-ir exit wrong");
    property p_exit2_ir;
        tap.tck_rise && state_reg == ST_E2IR |=> state_reg == ($past(tap.tms) ? ST_UIR : ST_SHIR);
    endproperty
    a_exit2_ir: assert property (p_exit2_ir) else $error("exit2-ir exit wrong");
    property p_upd_ir;
        tap.tck_rise && state_reg == ST_UIR |=> state_reg == ($past(tap.tms) ? ST_SDR : ST_RTI);
    endproperty
    a_upd_ir: assert property (p_upd_ir) else $error("update-ir exit wrong");
endmodule : bsi_tap_fsm
`default_nettype wire

// >>> bsi_scan_top.sv
// scan port: instruction path, decode, bypass, id and boundary registers, apb
// assumes scan pins are asynchronous to i_clk_sys and scan clock is much slower
`timescale 1ns/1ps
`default_nettype none
module bsi_scan_top #(
    parameter int BSR_LEN = bsi_pkg::BSR_LEN_DEF,
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] PART_NUMBER = 16'h00A5, // arbitrary value
    parameter logic [10:0] MANUF_ID = 11'h2B3 // arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_scan_clock_pin,
    input wire logic i_scan_mode_select_pin,
    input wire logic i_scan_serial_in_pin,
    input wire logic i_scan_reset_pin_b,
    output logic o_scan_serial_out_pin,
    output logic o_scan_serial_out_pin_oe,
    input wire logic [BSR_LEN-1:0] i_pin_in,
    input wire logic [BSR_LEN-1:0] i_core_out,
    input wire logic [BSR_LEN-1:0] i_core_oe,
    output logic [BSR_LEN-1:0] o_pin_out,
    output logic [BSR_LEN-1:0] o_pin_oe,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [bsi_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [bsi_pkg::DATA_W-1:0] i_pwdata,
    output logic [bsi_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    import bsi_pkg::*;

    if (BSR_LEN < 1 || BSR_LEN > DATA_W) begin : g_chk
        $error("BSR_LEN must be 1 to 32");
    end

    localparam int SYNC_W = 3 + BSR_LEN;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, PART_NUMBER, MANUF_ID, 1'b1};

    bsi_tap_if tap ();

    // reset synchroniser: asserts at once, releases two clocks later
    logic trst_s1_reg;
    logic trst_s2_reg;
    logic tap_rst_b;
    wire logic rst_comb_b = i_rst_b & i_scan_reset_pin_b;
    always_ff @(posedge i_clk_sys or negedge rst_comb_b) begin
        if (!rst_comb_b) begin
            trst_s1_reg <= 1'b0;
            trst_s2_reg <= 1'b0;
        end else begin
            trst_s1_reg <= 1'b1;
            trst_s2_reg <= trst_s1_reg;
        end
    end
    assign tap_rst_b = trst_s2_reg;

    // two-stage synchroniser for the scan clock, mode select, serial in and pin inputs
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic tck_d_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_pin_in, i_scan_serial_in_pin, i_scan_mode_select_pin, i_scan_clock_pin};
            sync2_reg <= sync1_reg;
            tck_d_reg <= sync2_reg[0];
        end
    end

    wire logic tck_s = sync2_reg[0];
    wire logic tdi_s = sync2_reg[2];
    wire logic [BSR_LEN-1:0] pins_s = sync2_reg[SYNC_W-1:3];
    wire logic tck_fall = tck_d_reg && !tck_s;
    logic ctrl_soft_rst_reg;

    assign tap.tck_rise = tck_s && !tck_d_reg;
    assign tap.tms = sync2_reg[1];
    assign tap.soft_rst = ctrl_soft_rst_reg;

    bsi_tap_fsm u_fsm (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(tap_rst_b),
        .tap(tap)
    );

    wire bsi_tap_state_t st = tap.state;
    wire logic rise = tap.tck_rise;

    // instruction register: shift stage and active latch
    logic [IR_LEN-1:0] ir_shift_reg;
    logic [IR_LEN-1:0] ir_reg;
    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            ir_shift_reg <= IR_CAPTURE;
        end else if (rise && st == ST_CIR) begin
            ir_shift_reg <= IR_CAPTURE;
        end else if (rise && st == ST_SHIR) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[IR_LEN-1:1]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            ir_reg <= INS_IDCODE;
        end else if (st == ST_TLR) begin
            ir_reg <= INS_IDCODE;
        end else if (tck_fall && st == ST_UIR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // decode; every other code selects the one-bit bypass
    wire logic sel_bsr = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE);
    wire logic sel_id = (ir_reg == INS_IDCODE);
    wire logic sel_byp = !sel_bsr && !sel_id;
    wire logic drive_bsr = (ir_reg == INS_EXTEST) || (ir_reg == INS_CLAMP);
    wire logic float_pins = (ir_reg == INS_HIGHZ);

    // data registers
    logic bypass_reg;
    logic [ID_LEN-1:0] id_shift_reg;
    logic [ID_LEN-1:0] id_latch_reg;
    logic [BSR_LEN-1:0] bsr_shift_reg;
    logic [BSR_LEN-1:0] bsr_latch_reg;

    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            bypass_reg <= 1'b0;
        end else if (rise && st == ST_CDR && sel_byp) begin
            bypass_reg <= 1'b0;
        end else if (rise && st == ST_SHDR && sel_byp) begin
            bypass_reg <= tdi_s;
        end
    end

    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            id_shift_reg <= ID_VALUE;
        end else if (rise && st == ST_CDR && sel_id) begin
            id_shift_reg <= ID_VALUE;
        end else if (rise && st == ST_SHDR && sel_id) begin
            id_shift_reg <= {tdi_s, id_shift_reg[ID_LEN-1:1]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            id_latch_reg <= ID_VALUE;
        end else if (tck_fall && st == ST_UDR && sel_id) begin
            id_latch_reg <= id_shift_reg;
        end
    end

    // sampling never touches the pin drivers, so normal function continues
    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            bsr_shift_reg <= '0;
        end else if (rise && st == ST_CDR && sel_bsr) begin
            bsr_shift_reg <= pins_s;
        end else if (rise && st == ST_SHDR && sel_bsr) begin
            bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
        end
    end

    // latch only moves under boundary instructions, so clamp holds it
    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            bsr_latch_reg <= '0;
        end else if (tck_fall && st == ST_UDR && sel_bsr) begin
            bsr_latch_reg <= bsr_shift_reg;
        end
    end

    // pin drivers
    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
        end else begin
            o_pin_out <= drive_bsr ? bsr_latch_reg : i_core_out;
            if (float_pins) begin
                o_pin_oe <= '0;
            end else if (drive_bsr) begin
                o_pin_oe <= '1;
            end else begin
                o_pin_oe <= i_core_oe;
            end
        end
    end

    // serial output changes on the falling scan clock, stable for the next rise
    always_ff @(posedge i_clk_sys or negedge tap_rst_b) begin
        if (!tap_rst_b) begin
            o_scan_serial_out_pin <= 1'b0;
            o_scan_serial_out_pin_oe <= 1'b0;
        end else if (tck_fall) begin
            o_scan_serial_out_pin_oe <= (st == ST_SHIR) || (st == ST_SHDR);
            if (st == ST_SHIR) begin
                o_scan_serial_out_pin <= ir_shift_reg[0];
            end else if (sel_id) begin
                o_scan_serial_out_pin <= id_shift_reg[0];
            end else if (sel_bsr) begin
                o_scan_serial_out_pin <= bsr_shift_reg[0];
            end else begin
                o_scan_serial_out_pin <= bypass_reg;
            end
        end
    end

    // apb slave: one wait state, answer registered
    wire logic apb_acc = i_psel && i_penable && !o_pready;
    wire logic apb_done = i_psel && i_penable && o_pready;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
        end else begin
            o_pready <= apb_acc;
            if (apb_acc) begin
                o_pslverr <= 1'b0;
                o_prdata <= '0;
                case (i_paddr)
                    OFF_PART_NUM: o_prdata[PN_W-1:0] <= PART_NUMBER;
                    OFF_CTRL: o_prdata[CTRL_SOFT_RST_BIT] <= ctrl_soft_rst_reg;
                    OFF_STATUS: begin
                        o_prdata[STAT_STATE_LSB +: 4] <= st;
                        o_prdata[STAT_INSTR_LSB +: IR_LEN] <= ir_reg;
                    end
                    OFF_ID_LATCH: o_prdata <= id_latch_reg;
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // read-only words ignore writes
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_soft_rst_reg <= CTRL_RESET;
        end else if (apb_done && i_pwrite && i_paddr == OFF_CTRL) begin
            ctrl_soft_rst_reg <= i_pwdata[CTRL_SOFT_RST_BIT];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!tap_rst_b);

    property p_ir_latch;
        tck_fall && st == ST_UIR |=> ir_reg == $past(ir_shift_reg);
    endproperty
    a_ir_latch: assert property (p_ir_latch) else $error("instruction not latched");
    property p_ir_shift;
        rise && st == ST_SHIR |=> $stable(ir_reg) && $stable(bsr_latch_reg)
            && ir_shift_reg[1:0] == $past(ir_shift_reg[2:1]);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("shift-ir wrong");
    property p_tlr_id;
        st == ST_TLR |=> ir_reg == INS_IDCODE && sel_id;
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset state not idcode");
    property p_id_load;
        rise && st == ST_CDR && sel_id |=> id_shift_reg == ID_VALUE && id_shift_reg[0];
    endproperty
    a_id_load: assert property (p_id_load) else $error("id not captured");
    property p_sample;
        rise && st == ST_CDR && sel_bsr |=> bsr_shift_reg == $past(pins_s);
    endproperty
    a_sample: assert property (p_sample) else $error("pins not sampled");
    property p_bypass;
        tck_fall && st == ST_SHDR && sel_byp |=> o_scan_serial_out_pin == $past(bypass_reg);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong");
    property p_extest;
        ir_reg == INS_EXTEST |=> o_pin_out == $past(bsr_latch_reg) && o_pin_oe == '1;
    endproperty
    a_extest: assert property (p_extest) else $error("extest not driving");
    property p_highz;
        ir_reg == INS_HIGHZ |=> o_pin_oe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("outputs not floated");
    property p_clamp;
        ir_reg == INS_CLAMP ##1 ir_reg == INS_CLAMP |-> $stable(bsr_latch_reg)
            ##1 o_pin_out == $past(bsr_latch_reg);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp outputs moved");
    property p_pn_read;
        apb_done && !i_pwrite && i_paddr == OFF_PART_NUM |->
            o_prdata == {16'h0000, PART_NUMBER} && !o_pslverr;
    endproperty
    a_pn_read: assert property (p_pn_read) else $error("part number read wrong");
    // spare codes must leave the pins on their normal drivers
    property p_unused_codes;
        ir_reg == 3'h5 || ir_reg == 3'h6 |-> sel_byp && !sel_bsr && !sel_id && !drive_bsr && !float_pins;
    endproperty
    a_unused_codes: assert property (p_unused_codes) else $error("spare code not bypass");
    property p_pause_hold;
        rise && st == ST_PIR |=> $stable(ir_shift_reg) && $stable(ir_reg);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause-ir moved register");
    property p_out_enable;
        tck_fall && (st == ST_SHIR || st == ST_SHDR) |=> o_scan_serial_out_pin_oe;
    endproperty
    a_out_enable: assert property (p_out_enable) else $error("serial out not driven");

    c_ir_update: cover property (tck_fall && st == ST_UIR);
    c_id_shift: cover property (rise && st == ST_SHDR && sel_id);
    c_extest: cover property (ir_reg == INS_EXTEST && tck_fall && st == ST_UDR);
    c_ir_pause: cover property (rise && st == ST_PIR);
endmodule : bsi_scan_top
`default_nettype wire

// >>> bsi_tester_model.sv
// external scan tester: drives scan clock, mode select, serial in and scan reset
// assumes the bench calls its tasks; the scan clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module bsi_tester_model (
    input wire logic i_clk_sys,
    input wire logic i_scan_serial_out_pin,
    output logic o_scan_clock_pin,
    output logic o_scan_mode_select_pin,
    output logic o_scan_serial_in_pin,
    output logic o_scan_reset_pin_b
);
    initial begin
        o_scan_clock_pin = 1'b0;
        o_scan_mode_select_pin = 1'b1;
        o_scan_serial_in_pin = 1'b0;
        o_scan_reset_pin_b = 1'b0;
    end

    task automatic set_reset(input logic v);
        @(posedge i_clk_sys);
        o_scan_reset_pin_b <= v;
    endtask : set_reset

    // one scan clock of 5 sys clocks low and 3 high (160 ns); serial out is
    // taken just before the rise, after it has settled from the last fall
    task automatic bit_cycle(input logic tms_v, input logic tdi_v, output logic tdo_v);
        @(posedge i_clk_sys);
        o_scan_mode_select_pin <= tms_v;
        o_scan_serial_in_pin <= tdi_v;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        tdo_v = i_scan_serial_out_pin;
        @(posedge i_clk_sys);
        o_scan_clock_pin <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        o_scan_clock_pin <= 1'b0;
        // serial in is not held past its bit, so a stale level cannot pass
        o_scan_serial_in_pin <= ~tdi_v;
    endtask : bit_cycle
endmodule : bsi_tester_model
`default_nettype wire

// >>> bsi_scan_top_test.sv
// self-checking bench for the scan instruction path: apb accesses and scan frames
// assumes the tester model paces the scan clock and a 32-cell boundary register
`timescale 1ns/1ps
`default_nettype none
module bsi_scan_top_test;
    import bsi_pkg::*;
    localparam logic [3:0] VER = 4'h1; // arbitrary value
    localparam logic [15:0] PN = 16'h00A5; // arbitrary value
    localparam logic [10:0] MFR = 11'h2B3; // arbitrary value
    localparam logic [31:0] ID_EXP = {VER, PN, MFR, 1'b1};
    localparam logic [31:0] PIN_IN = 32'h1234_5676;
    localparam logic [31:0] CORE_OUT = 32'hA5A5_0F0F;
    localparam logic [31:0] CORE_OE = 32'h00FF_F00F;
    localparam logic [31:0] BSR_EXP = {3'b101, PIN_IN[31:3]};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sclk, tms, tdi, srst_b, tdo, tdo_oe, pready, pslverr, err;
    logic [31:0] pin_out, pin_oe, prdata, rd;
    int n_errors = 0;
    int n_compared = 0;

    always #10 clk = ~clk;

    // a released serial out shows the inverse, so a missing enable corrupts the data
    bsi_tester_model tester (.i_clk_sys(clk), .i_scan_serial_out_pin(tdo_oe ? tdo : ~tdo),
        .o_scan_clock_pin(sclk), .o_scan_mode_select_pin(tms),
        .o_scan_serial_in_pin(tdi), .o_scan_reset_pin_b(srst_b));

    bsi_scan_top #(.BSR_LEN(32), .ID_VERSION(VER), .PART_NUMBER(PN), .MANUF_ID(MFR)) dut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_scan_clock_pin(sclk),
        .i_scan_mode_select_pin(tms), .i_scan_serial_in_pin(tdi),
        .i_scan_reset_pin_b(srst_b), .o_scan_serial_out_pin(tdo),
        .o_scan_serial_out_pin_oe(tdo_oe), .i_pin_in(PIN_IN), .i_core_out(CORE_OUT),
        .i_core_oe(CORE_OE), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            $display("BAD at %0t: no bus answer", $time);
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic scan(input logic [63:0] tv, input logic [63:0] dv, input int n,
                        output logic [63:0] ov);
        ov = 64'h0000_0000_0000_0000;
        for (int i = 0; i < n; i++) tester.bit_cycle(tv[i], dv[i], ov[i]);
    endtask : scan

    initial begin
        logic [63:0] ov;
        logic [2:0] c;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        tester.set_reset(1'b1);
        repeat (4) @(posedge clk);
        apb(1'b0, OFF_PART_NUM, 32'h0000_0000);
        check(rd, {16'h0000, PN}, "part number");
        apb(1'b1, OFF_PART_NUM, 32'hFFFF_FFFF);
        apb(1'b0, OFF_PART_NUM, 32'h0000_0000);
        check(rd, {16'h0000, PN}, "part number after write");
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001, "unmapped error");
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0000, "control reset");
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        check({25'h0, rd[6:0]}, {25'h0, INS_IDCODE, ST_TLR}, "start state");
        // reset, idle, select-dr, capture-dr, 32 shifts, exit1-dr, update-dr, idle
        scan(64'h0000_0018_0000_0002, 64'h0000_0001_2345_6780, 38, ov);
        check(ov[35:4], ID_EXP, "id shift out");
        check({31'h0, tdo_oe}, 32'h0000_0000, "serial out released");
        apb(1'b0, OFF_ID_LATCH, 32'h0000_0000);
        check(rd, 32'h1234_5678, "id latch");
        $display("test reset and id done");
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            scan(64'h0C3, 64'({c, 4'h0}), 9, ov);
            check({29'h0, ov[6:4]}, {29'h0, IR_CAPTURE}, "ir capture");
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            check({25'h0, rd[6:0]}, {25'h0, c, ST_RTI}, "instruction");
            check(pin_oe, (c == 0 || c == 3) ? 32'hFFFF_FFFF : (c == 4) ? 32'h0000_0000
                  : CORE_OE, "pin enables");
            scan(64'h61, 64'h28, 8, ov);
            check({29'h0, ov[5:3]}, {29'h0, (c == 1) ? ID_EXP[2:0] : (c == 0 || c == 2) ?
                  PIN_IN[2:0] : 3'b010}, "data path");
            repeat (2) @(posedge clk);
            check(pin_out, (c == 0 || c == 3) ? BSR_EXP : CORE_OUT, "pin data");
        end
        $display("test instruction codes done");
        tester.set_reset(1'b0);
        repeat (3) @(posedge clk);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        check({25'h0, rd[6:0]}, {25'h0, INS_IDCODE, ST_TLR}, "scan reset");
        tester.set_reset(1'b1);
        repeat (4) @(posedge clk);
        // from reset go idle, then load 110 with a pause between the second and third bits
        scan(64'h1A46, 64'h840, 14, ov);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        check({25'h0, rd[6:0]}, {25'h0, 3'b110, ST_RTI}, "paused load");
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        check({25'h0, rd[6:0]}, {25'h0, INS_IDCODE, ST_TLR}, "soft reset");
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0001, "control readback");
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        $display("test resets and pause done");
        complete_run();
    end
endmodule : bsi_scan_top_test
`default_nettype wire
